/* File: dv/cell_register_async_control_test.sv */
`timescale 1ns/10ps
`default_nettype none
module cell_register_async_control_test;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        a, b, ld, d, rst_n, cell_q;
	logic        w_a, w_b, w_ld, w_d, w_rst_n;
	logic [5:0]  ded, w_ded, ded_data;
	int          fails, checked;

	far_logic fl (.pclk(pclk), .want_a(w_a), .want_b(w_b), .want_ld(w_ld), .want_d(w_d),
		.want_rst_n(w_rst_n), .want_ded(w_ded), .async_ctrl_a(a), .async_ctrl_b(b),
		.load_data_in(ld), .cell_d(d), .chip_reset_n(rst_n), .dedicated_in(ded));
	cell_register_async_control uut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .async_ctrl_a(a), .async_ctrl_b(b),
		.load_data_in(ld), .cell_d(d), .chip_reset_n(rst_n), .dedicated_in(ded),
		.cell_q(cell_q), .dedicated_data(ded_data));

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	task automatic results;
		$display("checked=%0d fails=%0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : results

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic tick(input int n);
		repeat (n) @(posedge pclk);
	endtask : tick

	// Entered just after an edge; one idle edge follows so a next call never re-drives psel in the same step
	task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= addr;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	// Capture the opposite value by clock, then apply controls while cell_d fights them
	task automatic mode_case(input logic [31:0] ctrl, input logic ia, ib, ild, iexp);
		apb(1'b1, cell_ctrl_pkg::CTRL_OFS, ctrl);
		w_d <= ~iexp;
		tick(5);
		check({31'h0, cell_q}, {31'h0, ~iexp});
		w_a <= ia;
		w_b <= ib;
		w_ld <= ild;
		tick(5);
		check({31'h0, cell_q}, {31'h0, iexp});
		w_a <= 1'b0;
		w_b <= 1'b0;
		tick(5);
		check({31'h0, cell_q}, {31'h0, ~iexp});
	endtask : mode_case

	task automatic regs_case;
		apb(1'b0, cell_ctrl_pkg::CTRL_OFS, 32'h0);
		check(rd, 32'h10);
		apb(1'b0, cell_ctrl_pkg::SOURCE_OFS, 32'h0);
		check(rd, 32'h766);
		apb(1'b0, 8'h0c, 32'h0);
		check({rd[29:0], pready, err}, 32'h3);
	endtask : regs_case

	task automatic polarity_case;
		apb(1'b1, cell_ctrl_pkg::CTRL_OFS, 32'h10);
		w_a <= 1'b1;
		tick(5);
		apb(1'b0, cell_ctrl_pkg::STATUS_OFS, 32'h0);
		check(rd, 32'h18);
		w_a <= 1'b0;
		tick(5);
	endtask : polarity_case

	task automatic chip_case;
		apb(1'b1, cell_ctrl_pkg::CTRL_OFS, 32'h12);
		w_a <= 1'b1;
		w_ld <= 1'b1;
		tick(5);
		check({31'h0, cell_q}, 32'h1);
		w_rst_n <= 1'b0;
		tick(5);
		check({31'h0, cell_q}, 32'h0);
		w_rst_n <= 1'b1;
		w_a <= 1'b0;
		tick(5);
	endtask : chip_case

	task automatic dedicated_case;
		w_ded <= 6'h2a;
		tick(5);
		check({26'h0, ded_data}, 32'h2a);
		w_ded <= 6'h00;
		w_d <= 1'b0;
		apb(1'b1, cell_ctrl_pkg::SOURCE_OFS, 32'h760);
		tick(5);
		check({31'h0, cell_q}, 32'h0);
		w_ded <= 6'h01;
		tick(5);
		check({31'h0, cell_q}, 32'h1);
		w_ded <= 6'h00;
		tick(5);
		// Clock enable from dedicated input 1: held low, capture must stop
		apb(1'b1, cell_ctrl_pkg::SOURCE_OFS, 32'h166);
		w_d <= 1'b1;
		tick(5);
		check({31'h0, cell_q}, 32'h0);
		w_ded <= 6'h02;
		tick(5);
		check({31'h0, cell_q}, 32'h1);
		w_ded <= 6'h00;
		apb(1'b1, cell_ctrl_pkg::SOURCE_OFS, 32'h766);
		tick(2);
	endtask : dedicated_case

	initial begin
		#200us;
		fails++;
		results();
	end

	initial begin
		fails = 0;
		checked = 0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		w_a = 1'b0;
		w_b = 1'b0;
		w_ld = 1'b0;
		w_d = 1'b0;
		w_rst_n = 1'b1;
		w_ded = 6'h00;
		tick(2);
		presetn <= 1'b1;
		tick(1);
		regs_case();
		mode_case(32'h10, 1'b1, 1'b0, 1'b1, 1'b0);
		mode_case(32'h10, 1'b0, 1'b1, 1'b1, 1'b0);
		mode_case(32'h11, 1'b1, 1'b0, 1'b0, 1'b1);
		mode_case(32'h19, 1'b1, 1'b0, 1'b0, 1'b1);
		mode_case(32'h12, 1'b1, 1'b0, 1'b1, 1'b1);
		mode_case(32'h12, 1'b0, 1'b1, 1'b1, 1'b0);
		mode_case(32'h13, 1'b1, 1'b0, 1'b1, 1'b1);
		mode_case(32'h13, 1'b1, 1'b0, 1'b0, 1'b0);
		mode_case(32'h13, 1'b0, 1'b1, 1'b1, 1'b0);
		mode_case(32'h13, 1'b1, 1'b1, 1'b1, 1'b0);
		mode_case(32'h14, 1'b0, 1'b1, 1'b0, 1'b1);
		mode_case(32'h14, 1'b1, 1'b0, 1'b0, 1'b0);
		mode_case(32'h14, 1'b1, 1'b0, 1'b1, 1'b1);
		mode_case(32'h15, 1'b1, 1'b0, 1'b1, 1'b1);
		mode_case(32'h15, 1'b1, 1'b0, 1'b0, 1'b0);
		polarity_case();
		chip_case();
		dedicated_case();
		results();
	end
endmodule : cell_register_async_control_test
`default_nettype wire

/* File: dv/far_logic.sv */
`timescale 1ns/10ps
`default_nettype none
module far_logic (
	// Clock
	input  wire logic       pclk,
	// Wanted pin levels from the bench
	input  wire logic       want_a,
	input  wire logic       want_b,
	input  wire logic       want_ld,
	input  wire logic       want_d,
	input  wire logic       want_rst_n,
	input  wire logic [5:0] want_ded,
	// Pins towards the cell
	output logic            async_ctrl_a,
	output logic            async_ctrl_b,
	output logic            load_data_in,
	output logic            cell_d,
	output logic            chip_reset_n,
	output logic      [5:0] dedicated_in
);
	// User logic is registered, so pins only move just after an edge
	initial begin
		async_ctrl_a = 1'b0;
		async_ctrl_b = 1'b0;
		load_data_in = 1'b0;
		cell_d = 1'b0;
		chip_reset_n = 1'b1;
		dedicated_in = 6'h00;
	end
	always @(posedge pclk) begin
		async_ctrl_a <= want_a;
		async_ctrl_b <= want_b;
		load_data_in <= want_ld;
		cell_d <= want_d;
		chip_reset_n <= want_rst_n;
		dedicated_in <= want_ded;
	end
endmodule : far_logic
`default_nettype wire

/* File: rtl/cell_ctrl_pkg.sv */
package cell_ctrl_pkg;

	// Register byte offsets
	localparam logic [7:0] CTRL_OFS   = 8'h00;
	localparam logic [7:0] SOURCE_OFS = 8'h04;
	localparam logic [7:0] STATUS_OFS = 8'h08;

	// Control register fields
	localparam int CTRL_MODE_LSB  = 0;
	localparam int CTRL_EMUL_BIT  = 3;
	localparam int CTRL_CHIP_BIT  = 4;

	// Source register fields, three bits each
	localparam int SRC_A_LSB  = 0;
	localparam int SRC_B_LSB  = 4;
	localparam int SRC_CE_LSB = 8;

	// Status register fields
	localparam int ST_Q_BIT     = 0;
	localparam int ST_RAW_BIT   = 1;
	localparam int ST_CLRN_BIT  = 2;
	localparam int ST_PREN_BIT  = 3;
	localparam int ST_A_BIT     = 4;
	localparam int ST_B_BIT     = 5;
	localparam int ST_CHIP_BIT  = 6;

	// Number of dedicated low-skew inputs
	localparam int DEDICATED_COUNT = 6;

	// Source codes: 0..5 pick a dedicated input
	localparam logic [2:0] SRC_LINE = 3'h6;
	localparam logic [2:0] SRC_NONE = 3'h7;

	typedef enum logic [2:0] {
		MODE_CLEAR,
		MODE_PRESET,
		MODE_PRESET_CLEAR,
		MODE_LOAD_CLEAR,
		MODE_LOAD_PRESET,
		MODE_LOAD
	} mode_t;

	// Values after reset
	localparam logic [2:0] MODE_RST   = 3'h0;
	localparam logic       EMUL_RST   = 1'b0;
	localparam logic       CHIP_RST   = 1'b1;
	localparam logic [2:0] SRC_A_RST  = 3'h6;
	localparam logic [2:0] SRC_B_RST  = 3'h6;
	localparam logic [2:0] SRC_CE_RST = 3'h7;

	// Synchroniser depth in cycles
	localparam int SYNC_STAGES = 2;

endpackage : cell_ctrl_pkg

/* File: rtl/cell_register_async_control.sv */
// What this block does
// - Clear mode: either line clears, preset unused
// - Preset mode: line a loads a one
// - Emulated preset: clear with inverted input/output
// - Single-line preset leaves load_data_in free
// - Preset-clear: a presets, b clears
// - Load-clear: a loads data, b clears only
// - Load-preset: inverted register, b presets, a loads
// - Load-preset: load data inverted before register
// - Load-only: a loads data via both paths
// - Six dedicated inputs selectable as controls, always mirrored out as data
// - Controls active low, unused tied high
// - Chip-wide reset overrides all other controls
`timescale 1ns/10ps
`default_nettype none
module cell_register_async_control #(
	parameter int DED_W = cell_ctrl_pkg::DEDICATED_COUNT
) (
	// APB clock and reset
	input  wire logic             pclk,
	input  wire logic             presetn,
	// APB slave
	input  wire logic             psel,
	input  wire logic             penable,
	input  wire logic             pwrite,
	input  wire logic [7:0]       paddr,
	input  wire logic [31:0]      pwdata,
	output logic      [31:0]      prdata,
	output logic                  pready,
	output logic                  pslverr,
	// Cluster control lines and cell inputs, asynchronous
	input  wire logic             async_ctrl_a,
	input  wire logic             async_ctrl_b,
	input  wire logic             load_data_in,
	input  wire logic             cell_d,
	input  wire logic             chip_reset_n,
	input  wire logic [DED_W-1:0] dedicated_in,
	// Cell outputs
	output logic                  cell_q,
	output logic      [DED_W-1:0] dedicated_data
);

	localparam int SW = 5 + DED_W;

	// Pin synchronisers
	logic [SW-1:0] sync_q;
	logic          a_pin;
	logic          b_pin;
	logic          d3;
	logic          din_s;
	logic          chip_n_s;
	logic [DED_W-1:0] ded_s;

	sync2 #(
		.W   (SW),
		.RST ({{(SW-1){1'b0}}, 1'b1})
	) u_sync (
		.clk   (pclk),
		.rst_n (presetn),
		.d     ({dedicated_in, async_ctrl_a, async_ctrl_b, load_data_in, cell_d, chip_reset_n}),
		.q     (sync_q)
	);

	assign chip_n_s = sync_q[0];
	assign din_s    = sync_q[1];
	assign d3       = sync_q[2];
	assign b_pin    = sync_q[3];
	assign a_pin    = sync_q[4];
	assign ded_s    = sync_q[SW-1:5];

	// Source picker, shared by both lines and the clock enable
	function automatic logic pick(input logic [2:0] sel, input logic [DED_W-1:0] ded,
		input logic line, input logic none_val);
		if (sel == cell_ctrl_pkg::SRC_LINE)
			pick = line;
		else if (sel == cell_ctrl_pkg::SRC_NONE || int'(sel) >= DED_W)
			pick = none_val;
		else
			pick = ded[sel];
	endfunction : pick

	// Configuration registers
	logic [2:0] mode_bits;
	logic       emul;
	logic       chip_en;
	logic [2:0] src_a;
	logic [2:0] src_b;
	logic [2:0] src_ce;
	logic [2:0] next_mode_bits;
	logic       next_emul;
	logic       next_chip_en;
	logic [2:0] next_src_a;
	logic [2:0] next_src_b;
	logic [2:0] next_src_ce;
	logic       wr_ctrl;
	logic       wr_src;
	logic       access;
	logic       mapped;

	assign access = psel && penable;
	assign mapped = paddr == cell_ctrl_pkg::CTRL_OFS || paddr == cell_ctrl_pkg::SOURCE_OFS
		|| paddr == cell_ctrl_pkg::STATUS_OFS;
	assign wr_ctrl = access && pwrite && paddr == cell_ctrl_pkg::CTRL_OFS;
	assign wr_src  = access && pwrite && paddr == cell_ctrl_pkg::SOURCE_OFS;

	always_comb begin
		next_mode_bits = mode_bits;
		next_emul      = emul;
		next_chip_en   = chip_en;
		next_src_a     = src_a;
		next_src_b     = src_b;
		next_src_ce    = src_ce;
		if (wr_ctrl) begin
			next_mode_bits = pwdata[cell_ctrl_pkg::CTRL_MODE_LSB +: 3];
			next_emul      = pwdata[cell_ctrl_pkg::CTRL_EMUL_BIT];
			next_chip_en   = pwdata[cell_ctrl_pkg::CTRL_CHIP_BIT];
		end
		if (wr_src) begin
			next_src_a  = pwdata[cell_ctrl_pkg::SRC_A_LSB +: 3];
			next_src_b  = pwdata[cell_ctrl_pkg::SRC_B_LSB +: 3];
			next_src_ce = pwdata[cell_ctrl_pkg::SRC_CE_LSB +: 3];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_bits <= cell_ctrl_pkg::MODE_RST;
			emul      <= cell_ctrl_pkg::EMUL_RST;
			chip_en   <= cell_ctrl_pkg::CHIP_RST;
			src_a     <= cell_ctrl_pkg::SRC_A_RST;
			src_b     <= cell_ctrl_pkg::SRC_B_RST;
			src_ce    <= cell_ctrl_pkg::SRC_CE_RST;
		end else begin
			mode_bits <= next_mode_bits;
			emul      <= next_emul;
			chip_en   <= next_chip_en;
			src_a     <= next_src_a;
			src_b     <= next_src_b;
			src_ce    <= next_src_ce;
		end
	end

	// Control steering
	cell_ctrl_pkg::mode_t mode;
	logic  a;
	logic  b;
	logic  ce;
	logic  chip;
	logic  inv;
	logic  clr_n;
	logic  pre_n;
	logic  raw;
	logic  next_raw;

	assign mode = cell_ctrl_pkg::mode_t'(mode_bits);
	assign a    = pick(src_a, ded_s, a_pin, 1'b0);
	assign b    = pick(src_b, ded_s, b_pin, 1'b0);
	assign ce   = pick(src_ce, ded_s, 1'b1, 1'b1);
	assign chip = chip_en && !chip_n_s;
	assign dedicated_data = ded_s;

	// Inverted-register modes store the complement of the visible bit
	assign inv = (mode == cell_ctrl_pkg::MODE_PRESET && emul) || mode == cell_ctrl_pkg::MODE_LOAD_PRESET;

	always_comb begin
		// Active low; anything a mode leaves unused stays high
		clr_n = 1'b1;
		pre_n = 1'b1;
		unique case (mode)
			cell_ctrl_pkg::MODE_CLEAR: begin
				clr_n = !(a || b);
			end
			cell_ctrl_pkg::MODE_PRESET: begin
				// Load value is a constant one, so load_data_in is never read here
				if (emul)
					clr_n = !a;
				else
					pre_n = !a;
			end
			cell_ctrl_pkg::MODE_PRESET_CLEAR: begin
				clr_n = !b;
				pre_n = !(a && !b);
			end
			cell_ctrl_pkg::MODE_LOAD_CLEAR: begin
				clr_n = !(b || (a && !d3));
				pre_n = !(a && d3 && !b);
			end
			cell_ctrl_pkg::MODE_LOAD_PRESET: begin
				// Raw bit holds the complement, so load data goes in inverted
				clr_n = !(b || (a && d3));
				pre_n = !(a && !d3 && !b);
			end
			cell_ctrl_pkg::MODE_LOAD: begin
				clr_n = !(a && !d3);
				pre_n = !(a && d3);
			end
			default: begin
				clr_n = 1'b1;
				pre_n = 1'b1;
			end
		endcase
		// Chip reset clears the raw bit: emulated-preset registers read back one
		if (chip) begin
			clr_n = 1'b0;
			pre_n = 1'b1;
		end
	end

	// Controls are sampled after two flops, so "asynchronous" here means
	// they override the clock regardless of clock enable, two cycles late.
	always_comb begin
		if (!clr_n)
			next_raw = 1'b0;
		else if (!pre_n)
			next_raw = 1'b1;
		else if (ce)
			next_raw = inv ? !din_s : din_s;
		else
			next_raw = raw;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			raw <= 1'b0;
		else
			raw <= next_raw;
	end

	assign cell_q = inv ? !raw : raw;

	// APB read path: data registered in setup, answered in access
	logic [31:0] status;
	logic [31:0] next_prdata;

	always_comb begin
		status = 32'h0000_0000;
		status[cell_ctrl_pkg::ST_Q_BIT]    = cell_q;
		status[cell_ctrl_pkg::ST_RAW_BIT]  = raw;
		status[cell_ctrl_pkg::ST_CLRN_BIT] = clr_n;
		status[cell_ctrl_pkg::ST_PREN_BIT] = pre_n;
		status[cell_ctrl_pkg::ST_A_BIT]    = a;
		status[cell_ctrl_pkg::ST_B_BIT]    = b;
		status[cell_ctrl_pkg::ST_CHIP_BIT] = chip;
		next_prdata = prdata;
		if (psel && !penable) begin
			next_prdata = 32'h0000_0000;
			if (!pwrite) begin
				if (paddr == cell_ctrl_pkg::CTRL_OFS) begin
					next_prdata[cell_ctrl_pkg::CTRL_MODE_LSB +: 3] = mode_bits;
					next_prdata[cell_ctrl_pkg::CTRL_EMUL_BIT]      = emul;
					next_prdata[cell_ctrl_pkg::CTRL_CHIP_BIT]      = chip_en;
				end else if (paddr == cell_ctrl_pkg::SOURCE_OFS) begin
					next_prdata[cell_ctrl_pkg::SRC_A_LSB +: 3]  = src_a;
					next_prdata[cell_ctrl_pkg::SRC_B_LSB +: 3]  = src_b;
					next_prdata[cell_ctrl_pkg::SRC_CE_LSB +: 3] = src_ce;
				end else if (paddr == cell_ctrl_pkg::STATUS_OFS) begin
					next_prdata = status;
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else
			prdata <= next_prdata;
	end

	assign pready  = 1'b1;
	assign pslverr = access && !mapped;

	// Checks
	logic quiet;
	assign quiet = !wr_ctrl && !chip;

	clear_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
		mode == cell_ctrl_pkg::MODE_CLEAR && (a || b) && !wr_ctrl |=> !cell_q && !raw)
		else $error("clear mode line did not clear");
	clear_no_pre_a: assert property (@(posedge pclk) disable iff (!presetn)
		mode == cell_ctrl_pkg::MODE_CLEAR |-> pre_n)
		else $error("preset active in clear mode");
	preset_load_a: assert property (@(posedge pclk) disable iff (!presetn)
		mode == cell_ctrl_pkg::MODE_PRESET && !emul && a && quiet |=> cell_q && raw)
		else $error("preset by load failed");
	preset_emul_a: assert property (@(posedge pclk) disable iff (!presetn)
		mode == cell_ctrl_pkg::MODE_PRESET && emul && a && quiet |-> !clr_n ##1 (cell_q && !raw))
		else $error("emulated preset failed");
	preset_free_d3_a: assert property (@(posedge pclk) disable iff (!presetn)
		mode == cell_ctrl_pkg::MODE_PRESET && $stable(mode_bits) && $stable(emul) && $stable(a) && $stable(chip)
		|-> $stable(clr_n) && $stable(pre_n))
		else $error("preset mode depends on load data");
	pre_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
		mode == cell_ctrl_pkg::MODE_PRESET_CLEAR && quiet && (a || b) |=> cell_q == !$past(b))
		else $error("preset-clear result wrong");
	load_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
		mode == cell_ctrl_pkg::MODE_LOAD_CLEAR && quiet && a && !b |=> cell_q == $past(d3))
		else $error("load with clear did not load");
	load_pre_b_a: assert property (@(posedge pclk) disable iff (!presetn)
		mode == cell_ctrl_pkg::MODE_LOAD_PRESET && quiet && b |=> cell_q && !raw)
		else $error("load with preset did not preset");
	load_pre_d_a: assert property (@(posedge pclk) disable iff (!presetn)
		mode == cell_ctrl_pkg::MODE_LOAD_PRESET && quiet && a && !b |=> cell_q == $past(d3) && raw != $past(d3))
		else $error("inverted load value wrong");
	load_only_a: assert property (@(posedge pclk) disable iff (!presetn)
		mode == cell_ctrl_pkg::MODE_LOAD && quiet && a |=> cell_q == $past(d3))
		else $error("load only failed");
	chip_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
		chip |=> !raw)
		else $error("chip reset not overriding");
	clear_wins_a: assert property (@(posedge pclk) disable iff (!presetn)
		!clr_n |-> pre_n ##1 !raw)
		else $error("clear did not win");

endmodule : cell_register_async_control
`default_nettype wire

/* File: rtl/sync2.sv */
`timescale 1ns/10ps
`default_nettype none
module sync2 #(
	parameter int             W   = 1,
	parameter logic [W-1:0]   RST = '0
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst_n,
	// Data
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] meta;

	// The first stage feeds only the second stage
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta <= RST;
			q    <= RST;
		end else begin
			meta <= d;
			q    <= meta;
		end
	end

endmodule : sync2
`default_nettype wire
